// ==== hdl/clk_xlate_pkg.sv ====
// Constants, tables and carrier types of the clock translator control block.
// Assumes a single 10 MHz clock and a plain register port with 8-bit address.
//
// Behaviour
// - each reference path has prescale, doubler, 14-bit divider
// - single differential mode disables the secondary path
// - crystal path doubles then uses 14-bit divider
// - failed active reference switches to the other
// - both failed selects crystal holdover if fitted
// - all mux inputs run at one frequency
// - VCO prescaler limited to five through eleven
// - two independent 10-bit output dividers
// - settings from straps or from serial registers
// - grounded strap is zero, open is one
// - all-zero strap codes select serial mode
// - input straps give identical settings to both paths
// - preset settings fix phase detector frequency
// - codes 1101 and 1110 have no crystal holdover
// - output strap codes 1 to 15 set prescaler and both dividers, higher codes take them from module parameters
// - feedback divider and pump current from module parameters, not from straps
// - choice pin picks reference unless register ignores it
// - lock indicator high while loop locked
package clk_xlate_pkg;

	localparam int DW = 16;
	localparam int AW = 8;

	// Register offsets.
	localparam logic [AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [AW-1:0] REG_R_PRI    = 8'h01;
	localparam logic [AW-1:0] REG_R_SEC    = 8'h02;
	localparam logic [AW-1:0] REG_R_XO     = 8'h03;
	localparam logic [AW-1:0] REG_SCALE    = 8'h04;
	localparam logic [AW-1:0] REG_P0       = 8'h05;
	localparam logic [AW-1:0] REG_P1       = 8'h06;
	localparam logic [AW-1:0] REG_P2       = 8'h07;
	localparam logic [AW-1:0] REG_FB_N     = 8'h08;
	localparam logic [AW-1:0] REG_PUMP     = 8'h09;
	localparam logic [AW-1:0] REG_STATUS   = 8'h0a;
	localparam logic [AW-1:0] REG_EVENTS   = 8'h0b;

	// Control field positions.
	localparam int CTRL_SINGLE_DIFF = 0;
	localparam int CTRL_PIN_IGNORE  = 1;
	localparam int CTRL_OM1_REG     = 2;
	localparam int CTRL_OM2_REG     = 3;
	localparam int CTRL_OM1_LSB     = 4;
	localparam int CTRL_OM2_LSB     = 7;
	localparam int SCALE_DIV5       = 0;
	localparam int SCALE_DBL        = 1;

	// Event bit positions.
	localparam int EV_PRI_FAIL = 0;
	localparam int EV_SEC_FAIL = 1;
	localparam int EV_HOLDOVER = 2;

	localparam logic [3:0] IN_CODE_SERIAL  = 4'h0;
	localparam logic [5:0] OUT_CODE_SERIAL = 6'h00;
	localparam logic [3:0] IN_CODE_NO_XO_A = 4'hd;
	localparam logic [3:0] IN_CODE_NO_XO_B = 4'he;
	localparam logic [3:0] P0_MIN          = 4'h5;
	localparam logic [3:0] P0_MAX          = 4'hb;
	localparam logic [5:0] OUT_ROWS_LAST   = 6'h0f;

	localparam logic [DW-1:0] RESET_ZERO = 16'h0000;

	typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_HOLDOVER} source_t;

	// Divider and scaler settings of the whole chain.
	typedef struct packed {
		logic        div5;
		logic        dbl;
		logic [13:0] r_pri;
		logic [13:0] r_sec;
		logic [13:0] r_xo;
		logic [3:0]  p0;
		logic [9:0]  p1;
		logic [9:0]  p2;
		logic [15:0] fb_n;
		logic [3:0]  pump;
	} chain_cfg_t;

	// Reference health as seen by the switchover logic.
	typedef struct packed {
		logic pri_ok;
		logic sec_ok;
		logic crystal_backup_input_fitted;
	} ref_health_t;

	// Input preset table, index is the input strap code.
	localparam logic [15:0] IN_DIV5 = 16'h0800;
	localparam logic [15:0] IN_DBL  = 16'h1843;
	localparam logic [13:0] IN_R [16] = '{14'h0000, 14'h0001, 14'h0060, 14'h0080,
		14'h0400, 14'h04bf, 14'h0c35, 14'h097e, 14'h0f00, 14'h12fc, 14'h1e00,
		14'h0c35, 14'h00c1, 14'h003b, 14'h0010, 14'h1388};
	localparam logic [13:0] IN_RXO [16] = '{14'h0000, 14'h0c35, 14'h0c35, 14'h0c35,
		14'h0c35, 14'h0c35, 14'h0c35, 14'h0c35, 14'h0c35, 14'h0c35, 14'h0c35,
		14'h0c35, 14'h0c35, 14'h0000, 14'h0000, 14'h0ea6};

	// Output preset table rows 0 to 15, index is the output strap code.
	localparam logic [9:0] OUT_P1 [16] = '{10'h000, 10'h003, 10'h003, 10'h003,
		10'h003, 10'h003, 10'h003, 10'h006, 10'h006, 10'h006, 10'h006, 10'h006,
		10'h00c, 10'h00c, 10'h00c, 10'h00c};
	localparam logic [9:0] OUT_P2 [16] = '{10'h000, 10'h003, 10'h006, 10'h00c,
		10'h02d, 10'h168, 10'h1e0, 10'h006, 10'h00c, 10'h02d, 10'h168, 10'h1e0,
		10'h00c, 10'h02d, 10'h168, 10'h1e0};
	localparam logic [3:0] OUT_P0_ROWS = 4'h5;

endpackage

// ==== hdl/clock_translator_preset_select.sv ====
// Strap decode, serial register file and reference switchover of the clock translator.
// Assumes straps and reference health inputs are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module clock_translator_preset_select #(
	parameter logic [3:0]  DFLT_P0   = 4'h5,
	parameter logic [9:0]  DFLT_P1   = 10'h001,
	parameter logic [9:0]  DFLT_P2   = 10'h001,
	parameter logic [15:0] DFLT_FB_N = 16'h0001,
	parameter logic [3:0]  DFLT_PUMP = 4'h0
) (
	// Clock and reset.
	input  wire logic                            mclk,
	input  wire logic                            rst,
	// Strap and control pins.
	input  wire logic [3:0]                      input_freq_straps,
	input  wire logic [5:0]                      output_freq_straps,
	input  wire logic                            reference_choice_pin,
	input  wire logic                            output_mode_strap_hi,
	input  wire logic                            output_mode_strap_mid,
	input  wire logic                            output_mode_strap_lo,
	// Reference health and loop state.
	input  wire clk_xlate_pkg::ref_health_t      health,
	input  wire logic                            loop_locked,
	// Register port.
	input  wire logic [clk_xlate_pkg::AW-1:0]    reg_addr,
	input  wire logic [clk_xlate_pkg::DW-1:0]    reg_wdata,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	output logic [clk_xlate_pkg::DW-1:0]         reg_rdata,
	// Chain configuration and status.
	output clk_xlate_pkg::chain_cfg_t            chain_cfg,
	output clk_xlate_pkg::source_t               mux_source,
	output logic                                 secondary_path_on,
	output logic                                 serial_mode,
	output logic [2:0]                           first_output_mode,
	output logic [2:0]                           second_output_mode,
	output logic                                 lock_indicator,
	output logic [2:0]                           events
);
	import clk_xlate_pkg::*;

	typedef struct packed {
		logic              loaded;
		logic              serial;
		logic [3:0]        in_code;
		chain_cfg_t        preset;
		chain_cfg_t        regs;
		logic [DW-1:0]     ctrl;
		logic [2:0]        om_strap;
		source_t           src;
		logic [2:0]        ev;
		logic              locked;
		logic [DW-1:0]     rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Preset decode of the strap codes.

	function automatic chain_cfg_t decode_presets(input logic [3:0] ic, input logic [5:0] oc);
		chain_cfg_t c;
		c = '0;
		c.div5  = IN_DIV5[ic];
		c.dbl   = IN_DBL[ic];
		c.r_pri = IN_R[ic];
		c.r_sec = IN_R[ic];
		c.r_xo  = IN_RXO[ic];
		if (oc <= OUT_ROWS_LAST) begin
			c.p0 = OUT_P0_ROWS;
			c.p1 = OUT_P1[oc[3:0]];
			c.p2 = OUT_P2[oc[3:0]];
		end else begin
			c.p0 = DFLT_P0;
			c.p1 = DFLT_P1;
			c.p2 = DFLT_P2;
		end
		c.fb_n = DFLT_FB_N;
		c.pump = DFLT_PUMP;
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic        sec_usable;
	logic        xo_usable;
	logic        pri_fail_ev;
	logic        sec_fail_ev;
	logic        hold_ev;
	logic        wr_hit;
	logic [DW-1:0] clr_mask;

	always_comb begin
		st_nxt = st_r;
		// Straps read ground as zero and open as one, so the level is taken as is.
		if (!st_r.loaded) begin
			st_nxt.loaded   = 1'b1;
			st_nxt.in_code  = input_freq_straps;
			st_nxt.serial   = (input_freq_straps == IN_CODE_SERIAL) ||
				(output_freq_straps == OUT_CODE_SERIAL);
			st_nxt.preset   = decode_presets(input_freq_straps, output_freq_straps);
			st_nxt.om_strap = {output_mode_strap_hi, output_mode_strap_mid,
				output_mode_strap_lo};
		end

		sec_usable = health.sec_ok && !st_r.ctrl[CTRL_SINGLE_DIFF];
		xo_usable  = health.crystal_backup_input_fitted && (st_r.in_code != IN_CODE_NO_XO_A) &&
			(st_r.in_code != IN_CODE_NO_XO_B);
		pri_fail_ev = 1'b0;
		sec_fail_ev = 1'b0;
		hold_ev     = 1'b0;

		case (st_r.src)
			SRC_PRIMARY: begin
				if (!health.pri_ok) begin
					pri_fail_ev = 1'b1;
					if (sec_usable) begin
						st_nxt.src = SRC_SECONDARY;
					end else if (xo_usable) begin
						st_nxt.src = SRC_HOLDOVER;
						hold_ev    = 1'b1;
					end
				end else if (!st_r.ctrl[CTRL_PIN_IGNORE] && reference_choice_pin &&
						sec_usable) begin
					st_nxt.src = SRC_SECONDARY;
				end
			end
			SRC_SECONDARY: begin
				if (!sec_usable) begin
					sec_fail_ev = health.sec_ok ? 1'b0 : 1'b1;
					if (health.pri_ok) begin
						st_nxt.src = SRC_PRIMARY;
					end else if (xo_usable) begin
						st_nxt.src = SRC_HOLDOVER;
						hold_ev    = 1'b1;
					end else if (st_r.ctrl[CTRL_SINGLE_DIFF]) begin
						// The secondary path is switched off, so it must not stay selected.
						st_nxt.src = SRC_PRIMARY;
					end
				end else if (!st_r.ctrl[CTRL_PIN_IGNORE] && !reference_choice_pin &&
						health.pri_ok) begin
					st_nxt.src = SRC_PRIMARY;
				end
			end
			SRC_HOLDOVER: begin
				if (health.pri_ok) begin
					st_nxt.src = SRC_PRIMARY;
				end else if (sec_usable) begin
					st_nxt.src = SRC_SECONDARY;
				end
			end
			default: begin
				st_nxt.src = SRC_PRIMARY;
			end
		endcase

		// Software clears events by writing ones; a new event wins over the clear.
		wr_hit   = reg_wr && (reg_addr == REG_EVENTS);
		clr_mask = wr_hit ? reg_wdata : RESET_ZERO;
		st_nxt.ev = (st_r.ev & ~clr_mask[2:0]) |
			{hold_ev, sec_fail_ev, pri_fail_ev};

		st_nxt.locked = loop_locked;

		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL:   st_nxt.ctrl = reg_wdata;
				REG_R_PRI:  st_nxt.regs.r_pri = reg_wdata[13:0];
				REG_R_SEC:  st_nxt.regs.r_sec = reg_wdata[13:0];
				REG_R_XO:   st_nxt.regs.r_xo = reg_wdata[13:0];
				REG_SCALE: begin
					st_nxt.regs.div5 = reg_wdata[SCALE_DIV5];
					st_nxt.regs.dbl  = reg_wdata[SCALE_DBL];
				end
				REG_P0: begin
					if (reg_wdata[3:0] >= P0_MIN && reg_wdata[3:0] <= P0_MAX &&
							reg_wdata[DW-1:4] == '0) begin
						st_nxt.regs.p0 = reg_wdata[3:0];
					end
				end
				REG_P1:     st_nxt.regs.p1 = reg_wdata[9:0];
				REG_P2:     st_nxt.regs.p2 = reg_wdata[9:0];
				REG_FB_N:   st_nxt.regs.fb_n = reg_wdata;
				REG_PUMP:   st_nxt.regs.pump = reg_wdata[3:0];
				default: begin
				end
			endcase
		end

		st_nxt.rdata = RESET_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL:   st_nxt.rdata = st_r.ctrl;
				REG_R_PRI:  st_nxt.rdata = {2'b00, st_r.regs.r_pri};
				REG_R_SEC:  st_nxt.rdata = {2'b00, st_r.regs.r_sec};
				REG_R_XO:   st_nxt.rdata = {2'b00, st_r.regs.r_xo};
				REG_SCALE:  st_nxt.rdata = {14'h0000, st_r.regs.dbl, st_r.regs.div5};
				REG_P0:     st_nxt.rdata = {12'h000, st_r.regs.p0};
				REG_P1:     st_nxt.rdata = {6'h00, st_r.regs.p1};
				REG_P2:     st_nxt.rdata = {6'h00, st_r.regs.p2};
				REG_FB_N:   st_nxt.rdata = st_r.regs.fb_n;
				REG_PUMP:   st_nxt.rdata = {12'h000, st_r.regs.pump};
				REG_STATUS: st_nxt.rdata = {8'h00, st_r.in_code, st_r.locked, st_r.serial,
					st_r.src};
				REG_EVENTS: st_nxt.rdata = {13'h0000, st_r.ev};
				default:    st_nxt.rdata = RESET_ZERO;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	always_comb begin
		chain_cfg = st_r.serial ? st_r.regs : st_r.preset;
		if (st_r.serial && st_r.regs.p0 < P0_MIN) begin
			chain_cfg.p0 = P0_MIN;
		end
		if (st_r.serial && st_r.ctrl[CTRL_OM1_REG]) begin
			first_output_mode = st_r.ctrl[CTRL_OM1_LSB +: 3];
		end else begin
			first_output_mode = st_r.om_strap;
		end
		if (st_r.serial && st_r.ctrl[CTRL_OM2_REG]) begin
			second_output_mode = st_r.ctrl[CTRL_OM2_LSB +: 3];
		end else begin
			second_output_mode = st_r.om_strap;
		end
	end

	assign mux_source        = st_r.src;
	assign secondary_path_on = !st_r.ctrl[CTRL_SINGLE_DIFF];
	assign serial_mode       = st_r.serial;
	assign lock_indicator    = st_r.locked;
	assign events            = st_r.ev;
	assign reg_rdata         = st_r.rdata;

endmodule

`default_nettype wire

// ==== tb/xlate_properties.sv ====
// Concurrent checks on the ports of the translator control block.
// Assumes straps change only while reset is held.
`timescale 1ns/1ps
`default_nettype none

module xlate_properties
	import clk_xlate_pkg::*;
(
	// Clock and reset.
	input wire logic       mclk,
	input wire logic       rst,
	// Pins and health.
	input wire logic [3:0] input_freq_straps,
	input wire logic [5:0] output_freq_straps,
	input wire ref_health_t health,
	input wire logic       loop_locked,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [15:0] reg_rdata,
	// Outputs.
	input wire chain_cfg_t chain_cfg,
	input wire source_t    mux_source,
	input wire logic       secondary_path_on,
	input wire logic       serial_mode,
	input wire logic       lock_indicator,
	input wire logic [2:0] events
);
	logic [1:0] up_r;
	logic       ready;
	logic       no_xo;

	// Counts edges since reset so the strap latch has settled.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	assign ready = up_r[1];
	assign no_xo = input_freq_straps == IN_CODE_NO_XO_A || input_freq_straps == IN_CODE_NO_XO_B;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence pri_lost;
		mux_source == SRC_PRIMARY && !health.pri_ok && health.sec_ok && secondary_path_on;
	endsequence
	sequence both_lost;
		!health.pri_ok && !health.sec_ok && health.crystal_backup_input_fitted && !no_xo;
	endsequence

	a_pri_switch_over: assert property (ready ##0 pri_lost |=>
		mux_source == SRC_SECONDARY && events[EV_PRI_FAIL]) else $error("no switch to secondary");
	a_holdover_entry: assert property (ready ##0 both_lost ##1 both_lost |->
		mux_source == SRC_HOLDOVER && events[EV_HOLDOVER]) else $error("holdover not entered");
	a_no_xo_holdover: assert property (no_xo |-> mux_source != SRC_HOLDOVER)
		else $error("holdover without crystal path");
	a_single_diff_off: assert property (!secondary_path_on [*2] |->
		mux_source != SRC_SECONDARY) else $error("secondary used in single mode");
	a_serial_decode: assert property (ready |-> serial_mode ==
		(input_freq_straps == IN_CODE_SERIAL || output_freq_straps == OUT_CODE_SERIAL))
		else $error("serial mode decode wrong");
	a_p0_in_range: assert property (ready |-> chain_cfg.p0 inside {[P0_MIN:P0_MAX]})
		else $error("prescaler out of range");
	a_lock_follows: assert property (ready |-> lock_indicator == $past(loop_locked))
		else $error("lock indicator wrong");
	a_events_sticky: assert property (!(reg_wr && reg_addr == REG_EVENTS) |=>
		(events & $past(events)) == $past(events)) else $error("event lost");
	a_rdata_idle: assert property (!reg_rd || reg_addr > REG_EVENTS |=> reg_rdata == RESET_ZERO)
		else $error("read data not zero");
endmodule

bind clock_translator_preset_select xlate_properties chk (.mclk, .rst, .input_freq_straps,
	.output_freq_straps, .health, .loop_locked, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
	.chain_cfg, .mux_source, .secondary_path_on, .serial_mode, .lock_indicator, .events);

`default_nettype wire

// ==== tb/ref_source_model.sv ====
// Reference sources and loop of the far side, driven by bench commands.
// Assumes commands change right after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none

module ref_source_model
	import clk_xlate_pkg::*;
#(
	parameter int LOCK_WAIT = 4
) (
	// Clock and commands.
	input wire logic  mclk,
	input wire logic  pri_on,
	input wire logic  sec_on,
	input wire logic  crystal_backup_input_on,
	// Far side state.
	output ref_health_t health,
	output logic      loop_locked
);
	ref_health_t h_r = '0;
	logic [3:0]  w_r = 4'h0;

	// Any change of the sources unlocks the loop for a while.
	always @(posedge mclk) begin
		h_r <= '{pri_on, sec_on, crystal_backup_input_on};
		if ({pri_on, sec_on, crystal_backup_input_on} != h_r) w_r <= LOCK_WAIT[3:0];
		else if (w_r != 4'h0) w_r <= w_r - 4'h1;
	end
	assign health = h_r;
	assign loop_locked = w_r == 4'h0;
endmodule

`default_nettype wire

// ==== tb/clock_translator_preset_select_tb_top.sv ====
// Self-checking bench of the clock translator control block.
// Assumes the source model drives health and lock.
`timescale 1ns/1ps
`default_nettype none

module clock_translator_preset_select_tb_top;
	import clk_xlate_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  in_s = 4'h1;
	logic [5:0]  out_s = 6'h01;
	logic        pin = 1'b0, oh = 1'b1, om = 1'b1, ol = 1'b1;
	logic        pri_on = 1'b1, sec_on = 1'b1, crystal_backup_input_on = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wd = 16'h0000, rdata;
	logic        wr = 1'b0, rd = 1'b0, ser, sp, lock, locked;
	logic [2:0]  m1, m2, ev;
	ref_health_t health;
	chain_cfg_t  cfg;
	source_t     src;
	int          mismatches = 0, total_checks = 0;

	always #50 mclk = ~mclk;

	ref_source_model #(.LOCK_WAIT(4)) srcm (.mclk, .pri_on, .sec_on, .crystal_backup_input_on, .health,
		.loop_locked(locked));
	clock_translator_preset_select dut (.mclk, .rst, .input_freq_straps(in_s),
		.output_freq_straps(out_s), .reference_choice_pin(pin), .output_mode_strap_hi(oh),
		.output_mode_strap_mid(om), .output_mode_strap_lo(ol), .health, .loop_locked(locked),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.chain_cfg(cfg), .mux_source(src), .secondary_path_on(sp), .serial_mode(ser),
		.first_output_mode(m1), .second_output_mode(m2), .lock_indicator(lock), .events(ev));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a; wd <= d; wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a; rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#10 check(rdata, exp);
	endtask
	task automatic restart(input logic [3:0] i, input logic [5:0] o);
		@(posedge mclk);
		rst <= 1'b1; in_s <= i; out_s <= o;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
	task automatic srcs(input logic p, input logic s, input logic x);
		@(posedge mclk);
		pri_on <= p; sec_on <= s; crystal_backup_input_on <= x;
		repeat (3) @(posedge mclk);
		#10;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_preset;
		restart(4'h1, 6'h01);
		check({cfg.div5, cfg.dbl}, 16'h0001);
		check(16'(cfg.r_pri), 16'h0001);
		check(16'(cfg.r_sec), 16'h0001);
		check(16'(cfg.r_xo), 16'h0c35);
		check({cfg.p0, cfg.p1, cfg.p2[1:0]}, {4'h5, 10'h003, 2'h3});
		check({ser, sp, lock, m1}, 16'h001f);
		check(cfg.fb_n, 16'h0001);
		wrr(REG_P1, 16'h0009);
		#10 check(16'(cfg.p1), 16'h0003);
		rdc(REG_STATUS, 16'h0018);
		$display("test preset done");
	endtask
	task automatic t_switch;
		srcs(1'b0, 1'b1, 1'b1);
		check({ev, 14'(src)}, {3'h1, 14'(SRC_SECONDARY)});
		srcs(1'b0, 1'b0, 1'b1);
		check({ev, 14'(src)}, {3'h7, 14'(SRC_HOLDOVER)});
		srcs(1'b1, 1'b0, 1'b1);
		check(16'(src), 16'(SRC_PRIMARY));
		srcs(1'b1, 1'b1, 1'b1);
		@(posedge mclk) pin <= 1'b1;
		srcs(1'b1, 1'b1, 1'b1);
		check(16'(src), 16'(SRC_SECONDARY));
		srcs(1'b1, 1'b0, 1'b1);
		check(16'(src), 16'(SRC_PRIMARY));
		srcs(1'b1, 1'b1, 1'b1);
		@(posedge mclk) pin <= 1'b0;
		wrr(REG_EVENTS, 16'h0007);
		#10 check(16'(ev), 16'h0000);
		$display("test switch done");
	endtask
	task automatic t_no_xo;
		restart(4'hd, 6'h2d);
		check(16'(cfg.r_pri), 16'h003b);
		srcs(1'b0, 1'b0, 1'b1);
		check(16'(src == SRC_HOLDOVER), 16'h0000);
		srcs(1'b1, 1'b1, 1'b1);
		$display("test no crystal done");
	endtask
	task automatic t_serial;
		restart(4'h0, 6'h01);
		check(16'(ser), 16'h0001);
		wrr(REG_CTRL, 16'h015c);
		#10 check({m1, m2}, 16'h002a);
		wrr(REG_R_PRI, 16'hffff);
		rdc(REG_R_PRI, 16'h3fff);
		wrr(REG_P0, 16'h000b);
		wrr(REG_P0, 16'h000c);
		#10 check(16'(cfg.p0), 16'h000b);
		rdc(8'h0c, 16'h0000);
		wrr(REG_CTRL, 16'h015d);
		srcs(1'b0, 1'b1, 1'b1);
		check({sp, 15'(src)}, 16'(SRC_HOLDOVER));
		srcs(1'b1, 1'b1, 1'b1);
		$display("test serial done");
	endtask

	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		complete_run();
	end
	initial begin
		t_preset();
		t_switch();
		t_no_xo();
		t_serial();
		complete_run();
	end
endmodule

`default_nettype wire
